// file: src/adcsc_top.sv
// scan controller: apb registers, trigger, sequencing and result store of one converter channel
// Behaviour
// R01: enable bit runs and clocks the converter
// R02: disable does terminate processing, then reads 0
// R03: software checks busy before changing configuration
// R04: start and end fields pick inputs 0-7
// R05: software keeps end not below start
// R06: alignment bit picks left or right justify
// R07: justified result zero fills unused bits
// R08: alignment change re-presents all stored results
// R09: mode bit picks continuous or one-time
// R10: trigger field picks software, timer, external
// R11: sampling time is field plus four
// R12: zero voltage range blocks all conversion (code checks it only before a scan starts; a running scan keeps converting)
// R13: software sets voltage range to supply
// R14: flag register holds overwrite and completion flags
// R15: write one clears a flag
// R16: enable register matches flags, resets zero
// R17: load sets completion, repeat load sets overwrite
// R18: interrupt request when enabled flag set
// R19: start bit starts or arms, zero terminates
// R20: busy reads one while converting
// R21: scan ascends, continuous wraps to start
`timescale 1ns/10ps
`default_nettype none
module adcsc_top
   import adcsc_pkg::*;
#(
   parameter int NCH = 8,
   parameter logic [4:0] TICK_DIV = ADCSC_TICK_DIV
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire adcsc_pkg::adcsc_apb_req_t I_APB,
   output adcsc_pkg::adcsc_apb_rsp_t O_APB,
   input wire logic I_EXT_TRIGGER_PIN,
   input wire logic I_TIMER_UNDERFLOW,
   input wire adcsc_pkg::adcsc_conv_rsp_t I_CONV,
   output adcsc_pkg::adcsc_conv_req_t O_CONV,
   output logic O_CONV_CLK_EN,
   output logic O_IRQ
);
   import adcsc_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SAMPLE = 4'b0010,
      S_CONVERT = 4'b0100,
      S_STOP = 4'b1000
   } adcsc_state_t;

   typedef struct packed {
      adcsc_state_t state;
      logic enable;
      logic start_bit;
      logic armed;
      logic stop_req;
      logic [2:0] cur;
      logic [3:0] smp_cnt;
      logic [15:0] trg;
      logic [15:0] cfg;
      logic [15:0] inte;
      logic ext_d;
      logic tmr_d;
      logic conv_start;
      logic [31:0] rdata;
   } adcsc_st_t;

   adcsc_st_t st_r, st_nxt;
   logic [11:0] res_mem_r [NCH];
   logic tick;
   logic [15:0] flags;
   logic flag_irq;
   logic wr_en;
   logic rd_en;
   logic clr_we;
   logic res_hit;
   logic [2:0] res_idx;
   logic trig_hit;
   logic range_ok;
   logic [2:0] sta_sel;
   logic [2:0] end_sel;
   logic cont_mode;
   logic [1:0] src_sel;

   // place a raw 12-bit result according to the alignment bit
   function automatic logic [15:0] align_result(input logic [11:0] v, input logic left);
      if (left) begin
         align_result = {v, 4'h0}; // [R07]
      end else begin
         align_result = {4'h0, v}; // [R07]
      end
   endfunction

   // offset decode for the block of result registers
   function automatic logic in_res(input logic [11:0] a);
      in_res = (a >= ADCSC_OFF_RES0) && (a < ADCSC_OFF_RES0 + 12'(4 * NCH)) && (a[1:0] == 2'h0);
   endfunction

   adcsc_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_run(st_r.enable || st_r.state != S_IDLE), // [R02]
      .o_tick(tick)
   );

   adcsc_flags #(
      .NCH(NCH)
   ) u_flags (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_load(I_CONV.done && st_r.state == S_CONVERT),
      .i_chan(I_CONV.chan),
      .i_clr_we(clr_we),
      .i_clr_mask(I_APB.pwdata[15:0]),
      .i_enables(st_r.inte),
      .o_flags(flags),
      .o_irq(flag_irq)
   );

   assign wr_en = I_APB.psel && I_APB.penable && I_APB.pwrite;
   assign rd_en = I_APB.psel && !I_APB.penable && !I_APB.pwrite;
   assign clr_we = wr_en && I_APB.paddr == ADCSC_OFF_INTF;
   assign res_hit = in_res(I_APB.paddr);
   assign res_idx = 3'((I_APB.paddr - ADCSC_OFF_RES0) >> 2);
   assign sta_sel = st_r.trg[ADCSC_TRG_STA_LSB +: 3]; // [R04]
   assign end_sel = st_r.trg[ADCSC_TRG_END_LSB +: 3]; // [R04]
   assign cont_mode = st_r.trg[ADCSC_TRG_MOD_BIT];
   assign src_sel = st_r.trg[ADCSC_TRG_SRC_LSB +: 2];
   assign range_ok = st_r.cfg[1:0] != 2'h0; // [R12]

   // trigger source selection; edges on the external pin (active low) and timer
   always_comb begin
      case (src_sel)
         ADCSC_SRC_SW: trig_hit = st_r.start_bit; // [R10]
         ADCSC_SRC_TMR: trig_hit = st_r.armed && I_TIMER_UNDERFLOW && !st_r.tmr_d; // [R10]
         ADCSC_SRC_EXT: trig_hit = st_r.armed && !I_EXT_TRIGGER_PIN && st_r.ext_d; // [R10]
         default: trig_hit = 1'b0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.conv_start = 1'b0;
      st_nxt.ext_d = I_EXT_TRIGGER_PIN;
      st_nxt.tmr_d = I_TIMER_UNDERFLOW;
      // register writes
      if (wr_en) begin
         case (I_APB.paddr)
            ADCSC_OFF_CTL: begin
               st_nxt.enable = I_APB.pwdata[ADCSC_CTL_EN_BIT]; // [R01]
               st_nxt.start_bit = I_APB.pwdata[ADCSC_CTL_ST_BIT]; // [R19]
               st_nxt.armed = I_APB.pwdata[ADCSC_CTL_ST_BIT]; // [R19]
               if (!I_APB.pwdata[ADCSC_CTL_ST_BIT] && st_r.state != S_IDLE) begin
                  st_nxt.stop_req = 1'b1; // [R19]
               end
               if (!I_APB.pwdata[ADCSC_CTL_EN_BIT] && st_r.enable) begin
                  st_nxt.stop_req = 1'b1; // [R02]
               end
            end
            ADCSC_OFF_TRG: st_nxt.trg = I_APB.pwdata[15:0] & ADCSC_TRG_MASK;
            ADCSC_OFF_CFG: st_nxt.cfg = I_APB.pwdata[15:0] & ADCSC_CFG_MASK;
            ADCSC_OFF_INTE: st_nxt.inte = I_APB.pwdata[15:0]; // [R16]
            default: st_nxt.trg = st_nxt.trg;
         endcase
      end
      // scan sequencer
      case (st_r.state)
         S_IDLE: begin
            st_nxt.stop_req = 1'b0;
            if (st_r.enable && range_ok && trig_hit) begin // [R12]
               st_nxt.state = S_SAMPLE;
               st_nxt.cur = sta_sel; // [R21]
               st_nxt.smp_cnt = 4'h0;
               st_nxt.armed = 1'b0;
            end
         end
         S_SAMPLE: begin
            if (tick) begin
               if (st_r.smp_cnt == 4'(st_r.trg[ADCSC_TRG_SMP_LSB +: 3]) + ADCSC_SMP_BASE - 4'h1) begin
                  st_nxt.state = S_CONVERT; // [R11]
                  st_nxt.conv_start = 1'b1;
               end else begin
                  st_nxt.smp_cnt = st_r.smp_cnt + 4'h1; // [R11]
               end
            end
         end
         S_CONVERT: begin
            if (I_CONV.done) begin
               st_nxt.smp_cnt = 4'h0;
               if (st_r.stop_req || !st_r.enable) begin
                  st_nxt.state = S_STOP; // [R19]
               end else if (st_r.cur < end_sel) begin
                  st_nxt.cur = st_r.cur + 3'h1; // [R21]
                  st_nxt.state = S_SAMPLE;
               end else if (cont_mode) begin // [R09]
                  st_nxt.cur = sta_sel; // [R21]
                  st_nxt.state = S_SAMPLE;
               end else begin
                  st_nxt.state = S_STOP; // [R09]
               end
            end
         end
         S_STOP: begin
            st_nxt.state = S_IDLE;
            st_nxt.stop_req = 1'b0;
            st_nxt.armed = st_r.start_bit && st_r.enable && !cont_mode;
         end
         default: st_nxt.state = S_IDLE;
      endcase
      // software start is level sensitive; the start bit clears when a software-triggered scan reaches S_STOP
      if (st_r.state == S_STOP && src_sel == ADCSC_SRC_SW) begin
         st_nxt.start_bit = 1'b0;
      end
      // read data
      st_nxt.rdata = 32'h0;
      if (rd_en) begin
         case (I_APB.paddr)
            ADCSC_OFF_CTL: begin
               st_nxt.rdata[ADCSC_CTL_EN_BIT] = st_r.enable || st_r.state != S_IDLE; // [R02]
               st_nxt.rdata[ADCSC_CTL_ST_BIT] = st_r.start_bit;
               st_nxt.rdata[ADCSC_CTL_BSY_BIT] = st_r.state != S_IDLE; // [R20]
               st_nxt.rdata[ADCSC_CTL_CUR_LSB +: 3] = st_r.cur;
            end
            ADCSC_OFF_TRG: st_nxt.rdata[15:0] = st_r.trg;
            ADCSC_OFF_CFG: st_nxt.rdata[15:0] = st_r.cfg;
            ADCSC_OFF_INTF: st_nxt.rdata[15:0] = flags; // [R14]
            ADCSC_OFF_INTE: st_nxt.rdata[15:0] = st_r.inte;
            default: begin
               if (res_hit) begin
                  // [R08]
                  st_nxt.rdata[15:0] = align_result(res_mem_r[res_idx], st_r.trg[ADCSC_TRG_ALN_BIT]); // [R06]
               end
            end
         endcase
      end
      if (I_RESET) begin
         st_nxt.state = S_IDLE;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         st_r <= '{state: S_IDLE, trg: ADCSC_TRG_RST, ext_d: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // raw results are stored unaligned so the alignment bit only affects reads
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         for (int i = 0; i < NCH; i++) begin
            res_mem_r[i] <= 12'h000;
         end
      end else if (I_CONV.done && st_r.state == S_CONVERT) begin
         res_mem_r[I_CONV.chan] <= I_CONV.value; // [R17]
      end
   end

   always_comb begin
      O_APB.pready = 1'b1;
      O_APB.prdata = st_r.rdata;
      O_APB.pslverr = 1'b0;
      O_CONV.start = st_r.conv_start;
      O_CONV.chan = st_r.cur;
      O_CONV.smp_cycles = 4'(st_r.trg[ADCSC_TRG_SMP_LSB +: 3]) + ADCSC_SMP_BASE; // [R11]
   end
   assign O_CONV_CLK_EN = st_r.enable || st_r.state != S_IDLE; // [R01]
   assign O_IRQ = flag_irq; // [R18]
endmodule
`default_nettype wire

// file: include/adcsc_pkg.sv
// package: register map, field layout, reset values and types of the scan controller
package adcsc_pkg;
   localparam logic [11:0] ADCSC_OFF_CTL = 12'h000;
   localparam logic [11:0] ADCSC_OFF_TRG = 12'h004;
   localparam logic [11:0] ADCSC_OFF_CFG = 12'h008;
   localparam logic [11:0] ADCSC_OFF_INTF = 12'h00c;
   localparam logic [11:0] ADCSC_OFF_INTE = 12'h010;
   localparam logic [11:0] ADCSC_OFF_RES0 = 12'h020;
   localparam int ADCSC_CTL_EN_BIT = 0;
   localparam int ADCSC_CTL_ST_BIT = 1;
   localparam int ADCSC_CTL_BSY_BIT = 10;
   localparam int ADCSC_CTL_CUR_LSB = 12;
   localparam int ADCSC_TRG_END_LSB = 11;
   localparam int ADCSC_TRG_STA_LSB = 8;
   localparam int ADCSC_TRG_ALN_BIT = 7;
   localparam int ADCSC_TRG_MOD_BIT = 6;
   localparam int ADCSC_TRG_SRC_LSB = 4;
   localparam int ADCSC_TRG_SMP_LSB = 0;
   localparam int ADCSC_INT_OV_LSB = 8;
   localparam logic [15:0] ADCSC_TRG_MASK = 16'h3ff7;
   localparam logic [15:0] ADCSC_CFG_MASK = 16'h0003;
   localparam logic [15:0] ADCSC_TRG_RST = 16'h0007;
   localparam logic [1:0] ADCSC_SRC_SW = 2'h0;
   localparam logic [1:0] ADCSC_SRC_TMR = 2'h1;
   localparam logic [1:0] ADCSC_SRC_EXT = 2'h3;
   localparam logic [3:0] ADCSC_SMP_BASE = 4'h4;
   localparam logic [4:0] ADCSC_TICK_DIV = 5'h04;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } adcsc_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } adcsc_apb_rsp_t;
   typedef struct packed {
      logic start;
      logic [2:0] chan;
      logic [3:0] smp_cycles;
   } adcsc_conv_req_t;
   typedef struct packed {
      logic done;
      logic [2:0] chan;
      logic [11:0] value;
   } adcsc_conv_rsp_t;
endpackage

// file: src/adcsc_tick.sv
// timer clock enable divider: one-cycle pulse every div cycles
`timescale 1ns/10ps
`default_nettype none
module adcsc_tick #(
   parameter logic [4:0] DIV = 5'h04
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_run,
   output logic o_tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } adcsc_tick_st_t;
   adcsc_tick_st_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!i_run) begin
         st_nxt.cnt = 5'h00;
      end else if (st_r.cnt == DIV - 5'h01) begin
         st_nxt.cnt = 5'h00;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 5'h01;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_tick = st_r.tick;
endmodule
`default_nettype wire

// file: src/adcsc_flags.sv
// per-input completion and overwrite flags with write-one-to-clear and enables
`timescale 1ns/10ps
`default_nettype none
module adcsc_flags #(
   parameter int NCH = 8
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_load,
   input wire logic [2:0] i_chan,
   input wire logic i_clr_we,
   input wire logic [15:0] i_clr_mask,
   input wire logic [15:0] i_enables,
   output logic [15:0] o_flags,
   output logic o_irq
);
   typedef struct packed {
      logic [NCH-1:0] ov;
      logic [NCH-1:0] cp;
   } adcsc_flag_st_t;
   adcsc_flag_st_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (i_clr_we) begin
         st_nxt.ov = st_r.ov & ~i_clr_mask[15:8]; // [R15]
         st_nxt.cp = st_r.cp & ~i_clr_mask[7:0]; // [R15]
      end
      if (i_load) begin
         st_nxt.cp[i_chan] = 1'b1; // [R17]
         if (st_r.cp[i_chan]) begin
            st_nxt.ov[i_chan] = 1'b1; // [R17]
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_flags = {st_r.ov, st_r.cp}; // [R14]
   assign o_irq = |(o_flags & i_enables); // [R18]
endmodule
`default_nettype wire

// file: bench/adcsc_top_props.sv
// checker: port properties of the scan controller
`timescale 1ns/10ps
`default_nettype none
module adcsc_top_props
   import adcsc_pkg::*;
#(
   parameter int NCH = 8,
   parameter logic [4:0] TICK_DIV = ADCSC_TICK_DIV
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire adcsc_pkg::adcsc_apb_req_t I_APB,
   input wire adcsc_pkg::adcsc_apb_rsp_t O_APB,
   input wire logic I_EXT_TRIGGER_PIN,
   input wire logic I_TIMER_UNDERFLOW,
   input wire adcsc_pkg::adcsc_conv_rsp_t I_CONV,
   input wire adcsc_pkg::adcsc_conv_req_t O_CONV,
   input wire logic O_CONV_CLK_EN,
   input wire logic O_IRQ
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   sequence s_rd;
      I_APB.psel && I_APB.penable && !I_APB.pwrite;
   endsequence
   sequence s_go;
      O_CONV.start ##1 !O_CONV.start;
   endsequence
   a_start_pulse: assert property (O_CONV.start |=> !O_CONV.start)
      else $error("start longer than one cycle");
   a_start_clk_on: assert property (O_CONV.start |-> O_CONV_CLK_EN)
      else $error("start without converter clock");
   a_sample_span: assert property (O_CONV.start |-> O_CONV.smp_cycles inside {[4:11]})
      else $error("sampling span out of range");
   a_chan_hold: assert property (s_go |-> $stable(O_CONV.chan))
      else $error("input changed during conversion");
   a_rd_upper_zero: assert property (s_rd |-> O_APB.prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_idle_rdata: assert property (!(I_APB.psel && I_APB.penable) |-> O_APB.prdata == 32'h0)
      else $error("read data outside access");
   a_apb_answer: assert property (O_APB.pready && !O_APB.pslverr)
      else $error("bus answer not ready or error");
   a_irq_cause: assert property ($rose(O_IRQ) |->
      $past(I_CONV.done || (I_APB.psel && I_APB.penable && I_APB.pwrite)))
      else $error("interrupt rose without cause");
endmodule
bind adcsc_top adcsc_top_props #(.NCH(NCH), .TICK_DIV(TICK_DIV)) u_adcsc_top_props (
   .I_CLK(I_CLK), .I_RESET(I_RESET), .I_APB(I_APB), .O_APB(O_APB),
   .I_EXT_TRIGGER_PIN(I_EXT_TRIGGER_PIN), .I_TIMER_UNDERFLOW(I_TIMER_UNDERFLOW),
   .I_CONV(I_CONV), .O_CONV(O_CONV), .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_IRQ(O_IRQ));
`default_nettype wire

// file: bench/adcsc_core_model.sv
// partner: behavioural conversion core
`timescale 1ns/10ps
`default_nettype none
module adcsc_core_model
   import adcsc_pkg::*;
(
   input wire logic i_clk,
   input wire adcsc_pkg::adcsc_conv_req_t i_req,
   output var adcsc_pkg::adcsc_conv_rsp_t o_rsp
);
   logic [2:0] chan_log[$];
   logic [3:0] smp_log[$];
   logic [2:0] ch = 3'h0;
   logic slow = 1'b0;
   int cnt = 0;
   initial o_rsp = '0;
   // answers alternate quick and slow; idle lines toggle
   always @(posedge i_clk) begin
      o_rsp <= '{1'b0, ~o_rsp.chan, ~o_rsp.value};
      if (cnt == 1) o_rsp <= '{1'b1, ch, {ch, 9'h0a5}};
      if (cnt > 0) cnt--;
      if (i_req.start) begin
         ch = i_req.chan;
         chan_log.push_back(i_req.chan);
         smp_log.push_back(i_req.smp_cycles);
         cnt = slow ? 9 : 3;
         slow = ~slow;
      end
   end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// testbench: registers, scans, triggers and shutdown
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import adcsc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ext_n = 1'b1;
   logic tmr = 1'b0;
   logic clk_en;
   logic irq;
   adcsc_apb_req_t req = '0;
   adcsc_apb_rsp_t rsp;
   adcsc_conv_rsp_t cr;
   adcsc_conv_req_t cq;
   logic [31:0] rd;
   int fail_count = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   adcsc_top #(.TICK_DIV(5'h01)) u_adcsc_top (.I_CLK(clk), .I_RESET(rst), .I_APB(req),
      .O_APB(rsp), .I_EXT_TRIGGER_PIN(ext_n), .I_TIMER_UNDERFLOW(tmr), .I_CONV(cr),
      .O_CONV(cq), .O_CONV_CLK_EN(clk_en), .O_IRQ(irq));
   adcsc_core_model u_adcsc_core_model (.i_clk(clk), .i_req(cq), .o_rsp(cr));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (rsp.pready !== 1'b1) @(posedge clk);
      rd = rsp.prdata;
      req <= '0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, ADCSC_OFF_CTL, 32'h0);
         n++;
      end while (rd[ADCSC_CTL_BSY_BIT] !== 1'b0 && n < 100);
      chk("idle", rd[ADCSC_CTL_BSY_BIT], 1'b0);
   endtask
   task automatic t_regs();
      rchk(ADCSC_OFF_TRG, 32'h7, "trg");
      rchk(ADCSC_OFF_INTE, 32'h0, "inte");
      rchk(ADCSC_OFF_INTF, 32'h0, "intf");
      rchk(12'h100, 32'h0, "unmapped");
      apb(1'b1, ADCSC_OFF_TRG, 32'hffff);
      rchk(ADCSC_OFF_TRG, 32'h3ff7, "trg mask");
      $display("regs done");
   endtask
   task automatic t_scan();
      apb(1'b1, ADCSC_OFF_CFG, 32'h3);
      apb(1'b1, ADCSC_OFF_INTE, 32'hff);
      apb(1'b1, ADCSC_OFF_TRG, 32'h2b00);
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      @(posedge clk);
      chk("clk en", clk_en, 1'b1);
      wait_idle();
      for (int i = 0; i < 3; i++) chk("chan", u_adcsc_core_model.chan_log[i], 3 + i);
      chk("smp", u_adcsc_core_model.smp_log[0], 32'h4);
      rchk(ADCSC_OFF_INTF, 32'h38, "cflags");
      chk("irq on", irq, 1'b1);
      rchk(ADCSC_OFF_RES0 + 12'h10, {20'h0, 3'h4, 9'h0a5}, "right");
      apb(1'b1, ADCSC_OFF_TRG, 32'h2b80);
      rchk(ADCSC_OFF_RES0 + 12'h10, {16'h0, 3'h4, 9'h0a5, 4'h0}, "left");
      apb(1'b1, ADCSC_OFF_INTF, 32'h8);
      rchk(ADCSC_OFF_INTF, 32'h30, "w1c");
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      wait_idle();
      rchk(ADCSC_OFF_INTF, 32'h3038, "ovflags");
      apb(1'b1, ADCSC_OFF_INTE, 32'h0);
      @(posedge clk);
      chk("irq off", irq, 1'b0);
      apb(1'b1, ADCSC_OFF_INTF, 32'hffff);
      $display("scan done");
   endtask
   task automatic t_range0();
      int n;
      n = u_adcsc_core_model.chan_log.size();
      apb(1'b1, ADCSC_OFF_CFG, 32'h0);
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      repeat (40) @(posedge clk);
      chk("blocked", u_adcsc_core_model.chan_log.size(), n);
      rchk(ADCSC_OFF_CTL, 32'h5003, "idle");
      apb(1'b1, ADCSC_OFF_CTL, 32'h1);
      apb(1'b1, ADCSC_OFF_CFG, 32'h3);
      $display("range done");
   endtask
   task automatic t_trig(input logic [1:0] src);
      int n;
      n = u_adcsc_core_model.chan_log.size();
      apb(1'b1, ADCSC_OFF_TRG, {16'h0, 2'h0, 3'h2, 3'h2, 2'h0, src, 4'h0});
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      repeat (20) @(posedge clk);
      chk("armed", u_adcsc_core_model.chan_log.size(), n);
      @(posedge clk);
      if (src == ADCSC_SRC_TMR) tmr <= 1'b1;
      else ext_n <= 1'b0;
      repeat (2) @(posedge clk);
      tmr <= 1'b0;
      ext_n <= 1'b1;
      repeat (4) @(posedge clk);
      wait_idle();
      chk("fired", u_adcsc_core_model.chan_log.size(), n + 1);
      chk("fired chan", u_adcsc_core_model.chan_log[n], 32'h2);
      apb(1'b1, ADCSC_OFF_CTL, 32'h1);
      $display("trigger %0d done", src);
   endtask
   task automatic t_cont();
      int n;
      n = u_adcsc_core_model.chan_log.size();
      apb(1'b1, ADCSC_OFF_TRG, 32'h3640);
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      repeat (150) @(posedge clk);
      apb(1'b1, ADCSC_OFF_CTL, 32'h1);
      wait_idle();
      chk("repeats", u_adcsc_core_model.chan_log.size() > n + 2, 1'b1);
      chk("wrap", u_adcsc_core_model.chan_log[n + 1], 32'h6);
      $display("continuous done");
   endtask
   task automatic t_off();
      int n;
      n = 0;
      apb(1'b1, ADCSC_OFF_CTL, 32'h3);
      repeat (8) @(posedge clk);
      apb(1'b1, ADCSC_OFF_CTL, 32'h0);
      do begin
         apb(1'b0, ADCSC_OFF_CTL, 32'h0);
         n++;
      end while (rd[ADCSC_CTL_EN_BIT] !== 1'b0 && n < 100);
      chk("enable", rd[ADCSC_CTL_EN_BIT], 1'b0);
      chk("busy off", rd[ADCSC_CTL_BSY_BIT], 1'b0);
      chk("clk off", clk_en, 1'b0);
      $display("off done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #60000;
      fail_count++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_scan();
      t_range0();
      t_trig(ADCSC_SRC_TMR);
      t_trig(ADCSC_SRC_EXT);
      t_cont();
      t_off();
      final_report();
   end
endmodule
`default_nettype wire
